/* File: core/eal_autoload.v */
// EEPROM autoload engine and strap-selected SMBus slave with an APB register port.
// Assumes synchronous pin inputs, a pull-up on the shared data line, and straps
// that are stable on the first clock edge after reset is released.
`timescale 1ns/1ns
`include "eal_regs.vh"
module eal_autoload #(parameter QTR_CYC = `EAL_SCL_QTR_CYC) (
	input wire CORE_CLK,
	input wire RESET_N,
	input wire MODE_STRAP_HIGH,
	input wire MODE_STRAP_LOW,
	input wire [3:0] GPIO,
	input wire TRANSPARENT_MODE,
	input wire MGMT_CLK_I,
	output wire MGMT_CLK_O,
	output wire MGMT_CLK_OE,
	input wire EEPROM_DATA_LINE_I,
	output wire EEPROM_DATA_LINE_O,
	output wire EEPROM_DATA_LINE_OE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output reg PSLVERR,
	output reg [23:0] CFG_CLASS_CODE,
	output reg [15:0] CFG_PREFETCH_CTRL,
	output reg [7:0] CFG_UNCORR_ERR_MASK,
	output reg [31:0] CFG_CLK_CTRL,
	output reg CFG_ISA_EN_RO,
	output wire LOAD_BUSY,
	output wire LOAD_DONE
);
	localparam [3:0] L_IDLE = 4'h0;
	localparam [3:0] L_START = 4'h1;
	localparam [3:0] L_DEVW = 4'h2;
	localparam [3:0] L_ADDR = 4'h3;
	localparam [3:0] L_RSTART = 4'h4;
	localparam [3:0] L_DEVR = 4'h5;
	localparam [3:0] L_READ = 4'h6;
	localparam [3:0] L_FLUSH = 4'h7;
	localparam [3:0] L_STOP = 4'h8;
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ADDR = 2'h1;
	localparam [1:0] S_WRX = 2'h2;
	localparam [1:0] S_RD = 2'h3;

	reg strap_cap_r;
	reg mode_high_r;
	reg mode_low_r;
	reg [3:0] gpio_r;
	reg [3:0] ld_st_r;
	reg wait_r;
	reg [7:0] idx_r;
	reg [7:0] stop_r;
	reg [7:0] sig_lo_r;
	reg misc_r;
	reg auto_pend_r;
	reg done_r;
	reg sig_ok_r;
	reg sig_fail_r;
	reg nack_r;
	reg [1:0] cmd_c;
	reg [7:0] wbyte_c;
	reg ack_c;
	reg [1:0] smb_st_r;
	reg [3:0] bcnt_r;
	reg [7:0] sh_r;
	reg sda_low_r;
	reg rw_r;
	reg mack_r;
	reg scl_q_r;
	reg sda_q_r;
	reg [31:0] rdata_c;
	reg hit_c;
	wire bdone;
	wire [7:0] brd;
	wire back;
	wire bscl;
	wire bsda;
	wire bsda_oe;

	wire ee_mode = strap_cap_r & ~mode_high_r & ~mode_low_r; // RULE_01
	wire smb_mode = strap_cap_r & ~mode_high_r & mode_low_r; // RULE_03
	wire [6:0] smb_addr = {`EAL_SMB_ADDR_HI, gpio_r}; // RULE_05
	wire busy = (ld_st_r != L_IDLE);
	wire cmd_valid = busy && !wait_r;
	wire apb_setup = PSEL & ~PENABLE;
	wire apb_wr = PSEL & PENABLE & PWRITE;
	wire sw_start = apb_wr && (PADDR == `EAL_OFF_CTRL) && PWDATA[`EAL_CTRL_START];
	wire go = ee_mode && !busy && (auto_pend_r || sw_start);
	wire [7:0] status = {CFG_ISA_EN_RO, smb_mode, ee_mode, nack_r, sig_fail_r, sig_ok_r,
		done_r, busy};

	assign LOAD_BUSY = busy;
	assign LOAD_DONE = done_r;
	assign PREADY = 1'b1;

	// Shared pins: pushed clock and two-way data as master, open-drain data as slave.
	assign MGMT_CLK_O = bscl; // RULE_02
	assign MGMT_CLK_OE = ee_mode; // RULE_04
	assign EEPROM_DATA_LINE_O = ee_mode ? bsda : 1'b0; // RULE_04
	assign EEPROM_DATA_LINE_OE = ee_mode ? bsda_oe : (smb_mode & sda_low_r); // RULE_02

	// Straps are caught on the first edge after reset release.
	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			strap_cap_r <= 1'b0;
			mode_high_r <= 1'b1;
			mode_low_r <= 1'b0;
			gpio_r <= 4'h0;
		end else if (!strap_cap_r) begin
			strap_cap_r <= 1'b1;
			mode_high_r <= MODE_STRAP_HIGH;
			mode_low_r <= MODE_STRAP_LOW;
			gpio_r <= GPIO;
		end
	end

	function [7:0] stop_of;
		input [3:0] code;
		begin
			case (code)
			`EAL_REGION_G1: stop_of = `EAL_STOP_G1;
			`EAL_REGION_G2: stop_of = `EAL_STOP_G2;
			`EAL_REGION_G3: stop_of = `EAL_STOP_G3;
			`EAL_REGION_G4: stop_of = `EAL_STOP_G4;
			default: stop_of = `EAL_STOP_G1;
			endcase
		end
	endfunction

	// Command chosen by the sequencer state.
	always @* begin
		cmd_c = `EAL_CMD_START;
		wbyte_c = 8'h00;
		ack_c = 1'b0;
		case (ld_st_r)
		L_DEVW: begin
			cmd_c = `EAL_CMD_WRITE;
			wbyte_c = `EAL_EE_DEV_WR;
		end
		L_ADDR: begin
			cmd_c = `EAL_CMD_WRITE;
			wbyte_c = `EAL_EE_FIRST; // RULE_13
		end
		L_DEVR: begin
			cmd_c = `EAL_CMD_WRITE;
			wbyte_c = `EAL_EE_DEV_RD;
		end
		L_READ: begin
			cmd_c = `EAL_CMD_READ;
			ack_c = (idx_r != stop_r);
		end
		L_FLUSH: cmd_c = `EAL_CMD_READ;
		L_STOP: cmd_c = `EAL_CMD_STOP;
		default: cmd_c = `EAL_CMD_START;
		endcase
	end

	eal_i2c_byte #(.QTR_CYC(QTR_CYC)) u_byte (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.cmd_valid(cmd_valid),
		.cmd(cmd_c),
		.wr_byte(wbyte_c),
		.ack_send(ack_c),
		.sda_in(EEPROM_DATA_LINE_I),
		.done(bdone),
		.rd_byte(brd),
		.ack_rcvd(back),
		.scl_out(bscl),
		.sda_out(bsda),
		.sda_oe(bsda_oe)
	);

	// Autoload sequencer and configuration field loading.
	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ld_st_r <= L_IDLE;
			wait_r <= 1'b0;
			idx_r <= 8'h00;
			stop_r <= `EAL_STOP_G1;
			sig_lo_r <= 8'h00;
			misc_r <= 1'b0;
			auto_pend_r <= 1'b1;
			done_r <= 1'b0;
			sig_ok_r <= 1'b0;
			sig_fail_r <= 1'b0;
			nack_r <= 1'b0;
			CFG_CLASS_CODE <= `EAL_RST_CLASS; // RULE_14
			CFG_PREFETCH_CTRL <= `EAL_RST_PREF; // RULE_14
			CFG_UNCORR_ERR_MASK <= `EAL_RST_ERRMASK; // RULE_14
			CFG_CLK_CTRL <= `EAL_RST_CLKCTL; // RULE_14
			CFG_ISA_EN_RO <= 1'b0;
		end else begin
			CFG_ISA_EN_RO <= misc_r & TRANSPARENT_MODE; // RULE_08
			if (strap_cap_r)
				auto_pend_r <= 1'b0;
			if (go) begin
				ld_st_r <= L_START;
				idx_r <= `EAL_EE_FIRST; // RULE_13
				stop_r <= `EAL_STOP_G1;
				done_r <= 1'b0;
				sig_ok_r <= 1'b0;
				sig_fail_r <= 1'b0;
				nack_r <= 1'b0;
			end else if (cmd_valid) begin
				wait_r <= 1'b1;
			end else if (busy && bdone) begin
				wait_r <= 1'b0;
				case (ld_st_r)
				L_START: ld_st_r <= L_DEVW;
				L_RSTART: ld_st_r <= L_DEVR;
				L_DEVW, L_ADDR, L_DEVR: begin
					if (back) begin
						nack_r <= 1'b1;
						ld_st_r <= L_STOP;
					end else if (ld_st_r == L_DEVW) begin
						ld_st_r <= L_ADDR;
					end else if (ld_st_r == L_ADDR) begin
						ld_st_r <= L_RSTART;
					end else begin
						ld_st_r <= L_READ;
					end
				end
				L_READ: begin
					idx_r <= idx_r + 8'h01; // RULE_13
					case (idx_r)
					`EAL_EE_FIRST: sig_lo_r <= brd;
					`EAL_EE_REGION: stop_r <= stop_of(brd[4:1]); // RULE_07
					`EAL_EE_MISC: misc_r <= brd[0]; // RULE_08
					`EAL_EE_CLASS0: CFG_CLASS_CODE[7:0] <= brd; // RULE_09
					`EAL_EE_CLASS1: CFG_CLASS_CODE[15:8] <= brd; // RULE_09
					`EAL_EE_CLASS2: CFG_CLASS_CODE[23:16] <= brd; // RULE_09
					`EAL_EE_PREF0: CFG_PREFETCH_CTRL[7:0] <= brd; // RULE_10
					`EAL_EE_PREF1: CFG_PREFETCH_CTRL[15:8] <= brd; // RULE_10
					`EAL_EE_ERRMASK: CFG_UNCORR_ERR_MASK <= brd; // RULE_11
					`EAL_EE_CLK0: CFG_CLK_CTRL[7:0] <= brd; // RULE_12
					`EAL_EE_CLK1: CFG_CLK_CTRL[15:8] <= brd; // RULE_12
					`EAL_EE_CLK2: CFG_CLK_CTRL[23:16] <= brd; // RULE_12
					`EAL_EE_CLK3: CFG_CLK_CTRL[31:24] <= brd; // RULE_12
					default: sig_lo_r <= sig_lo_r;
					endcase
					if (idx_r == stop_r) begin
						ld_st_r <= L_STOP; // RULE_07
					end else if (idx_r == `EAL_EE_SIG_HI) begin
						if ({brd, sig_lo_r} == `EAL_SIG_WORD) begin
							sig_ok_r <= 1'b1;
						end else begin
							sig_fail_r <= 1'b1; // RULE_06
							ld_st_r <= L_FLUSH; // RULE_06
						end
					end
				end
				L_FLUSH: ld_st_r <= L_STOP;
				L_STOP: begin
					ld_st_r <= L_IDLE;
					done_r <= 1'b1;
				end
				default: ld_st_r <= L_IDLE;
				endcase
			end
		end
	end

	// SMBus slave: acknowledges its strapped address, accepts writes, returns status.
	wire scl_rise = MGMT_CLK_I & ~scl_q_r;
	wire scl_fall = ~MGMT_CLK_I & scl_q_r;
	wire smb_start = MGMT_CLK_I & scl_q_r & sda_q_r & ~EEPROM_DATA_LINE_I;
	wire smb_stop = MGMT_CLK_I & scl_q_r & ~sda_q_r & EEPROM_DATA_LINE_I;

	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			smb_st_r <= S_IDLE;
			bcnt_r <= 4'h0;
			sh_r <= 8'h00;
			sda_low_r <= 1'b0;
			rw_r <= 1'b0;
			mack_r <= 1'b1;
		end else begin
			scl_q_r <= MGMT_CLK_I; // RULE_04
			sda_q_r <= EEPROM_DATA_LINE_I;
			if (!smb_mode || smb_stop) begin
				smb_st_r <= S_IDLE;
				sda_low_r <= 1'b0;
			end else if (smb_start) begin
				smb_st_r <= S_ADDR;
				bcnt_r <= 4'h0;
				sda_low_r <= 1'b0;
			end else if (smb_st_r != S_IDLE && scl_rise) begin
				bcnt_r <= bcnt_r + 4'h1;
				if (smb_st_r != S_RD && bcnt_r < 4'h8)
					sh_r <= {sh_r[6:0], EEPROM_DATA_LINE_I};
				if (smb_st_r == S_RD && bcnt_r == 4'h8)
					mack_r <= EEPROM_DATA_LINE_I;
			end else if (smb_st_r != S_IDLE && scl_fall) begin
				if (bcnt_r == 4'h8) begin
					if (smb_st_r == S_ADDR && sh_r[7:1] != smb_addr) begin
						smb_st_r <= S_IDLE; // RULE_05
						sda_low_r <= 1'b0;
					end else begin
						sda_low_r <= (smb_st_r != S_RD); // RULE_05
						if (smb_st_r == S_ADDR)
							rw_r <= sh_r[0];
					end
				end else if (bcnt_r == 4'h9) begin
					bcnt_r <= 4'h0;
					if ((smb_st_r == S_ADDR && rw_r) || (smb_st_r == S_RD && !mack_r)) begin
						smb_st_r <= S_RD;
						sh_r <= status;
						sda_low_r <= ~status[7];
					end else if (smb_st_r == S_RD) begin
						smb_st_r <= S_IDLE;
						sda_low_r <= 1'b0;
					end else begin
						smb_st_r <= S_WRX;
						sda_low_r <= 1'b0;
					end
				end else if (smb_st_r == S_RD) begin
					sda_low_r <= ~sh_r[6];
					sh_r <= {sh_r[6:0], 1'b1};
				end
			end
		end
	end

	// APB read decode.
	always @* begin
		hit_c = 1'b1;
		rdata_c = 32'h00000000;
		case (PADDR)
		`EAL_OFF_CTRL: rdata_c = 32'h00000000;
		`EAL_OFF_STATUS: rdata_c = {24'h000000, status};
		`EAL_OFF_CLASS: rdata_c = {8'h00, CFG_CLASS_CODE};
		`EAL_OFF_PREF: rdata_c = {16'h0000, CFG_PREFETCH_CTRL};
		`EAL_OFF_ERRMASK: rdata_c = {24'h000000, CFG_UNCORR_ERR_MASK};
		`EAL_OFF_CLKCTL: rdata_c = CFG_CLK_CTRL;
		`EAL_OFF_SMBADDR: rdata_c = {24'h000000, smb_addr, 1'b0};
		default: hit_c = 1'b0;
		endcase
	end

	// Read data and error are captured in the setup cycle; the access phase never waits.
	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (apb_setup) begin
			PRDATA <= PWRITE ? 32'h00000000 : rdata_c;
			PSLVERR <= ~hit_c;
		end
	end
endmodule

/* File: core/eal_i2c_byte.v */
// I2C master byte engine: start, stop, byte write and byte read.
// Assumes a pulled-up data line and a memory that does not stretch the clock.
`timescale 1ns/1ns
`include "eal_regs.vh"
module eal_i2c_byte #(
	parameter QTR_CYC = `EAL_SCL_QTR_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire cmd_valid,
	input wire [1:0] cmd,
	input wire [7:0] wr_byte,
	input wire ack_send,
	input wire sda_in,
	output reg done,
	output reg [7:0] rd_byte,
	output reg ack_rcvd,
	output reg scl_out,
	output reg sda_out,
	output reg sda_oe
);
	localparam [31:0] QTR_LAST = QTR_CYC - 1;
	reg busy_r;
	reg [1:0] cmd_r;
	reg [7:0] qcnt_r;
	reg [1:0] qtr_r;
	reg [3:0] bit_r;
	reg [8:0] tx_r;
	reg [8:0] rx_r;
	wire qtr_end = busy_r && (qcnt_r == QTR_LAST[7:0]);
	wire slot_last = (cmd_r == `EAL_CMD_WRITE || cmd_r == `EAL_CMD_READ) ? (bit_r == 4'h8) : 1'b1;

	// Pin levels {scl, sda, oe} for one quarter of a bit slot.
	function [2:0] pins;
		input [1:0] c;
		input [1:0] q;
		input b;
		input rel;
		begin
			case (c)
			`EAL_CMD_START: pins = {q[0] ^ q[1], ~q[1], 1'b1};
			`EAL_CMD_STOP: pins = {q != 2'h0, q[1], 1'b1};
			default: pins = {q[0] ^ q[1], b, ~rel};
			endcase
		end
	endfunction

	function rel_of;
		input [1:0] c;
		input [3:0] n;
		begin
			rel_of = (c == `EAL_CMD_WRITE) ? (n == 4'h8) : ((c == `EAL_CMD_READ) && (n != 4'h8));
		end
	endfunction

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cmd_r <= `EAL_CMD_STOP;
			qcnt_r <= 8'h00;
			qtr_r <= 2'h0;
			bit_r <= 4'h0;
			tx_r <= 9'h1ff;
			rx_r <= 9'h000;
			done <= 1'b0;
			rd_byte <= 8'h00;
			ack_rcvd <= 1'b0;
			scl_out <= 1'b1;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy_r && cmd_valid) begin
				busy_r <= 1'b1;
				cmd_r <= cmd;
				qcnt_r <= 8'h00;
				qtr_r <= 2'h0;
				bit_r <= 4'h0;
				tx_r <= (cmd == `EAL_CMD_READ) ? {8'hff, ~ack_send} : {wr_byte, 1'b1};
				{scl_out, sda_out, sda_oe} <= pins(cmd, 2'h0,
					(cmd == `EAL_CMD_READ) ? 1'b1 : wr_byte[7], rel_of(cmd, 4'h0)); // RULE_02
			end else if (busy_r) begin
				qcnt_r <= qtr_end ? 8'h00 : qcnt_r + 8'h01;
				if (qtr_end && qtr_r == 2'h1)
					rx_r <= {rx_r[7:0], sda_in};
				if (qtr_end && qtr_r != 2'h3) begin
					qtr_r <= qtr_r + 2'h1;
					{scl_out, sda_out, sda_oe} <= pins(cmd_r, qtr_r + 2'h1, tx_r[8],
						rel_of(cmd_r, bit_r));
				end else if (qtr_end && !slot_last) begin
					qtr_r <= 2'h0;
					bit_r <= bit_r + 4'h1;
					tx_r <= {tx_r[7:0], 1'b1};
					{scl_out, sda_out, sda_oe} <= pins(cmd_r, 2'h0, tx_r[7],
						rel_of(cmd_r, bit_r + 4'h1));
				end else if (qtr_end) begin
					busy_r <= 1'b0;
					done <= 1'b1;
					rd_byte <= rx_r[8:1];
					ack_rcvd <= rx_r[0];
					if (cmd_r == `EAL_CMD_STOP)
						sda_oe <= 1'b0;
				end
			end
		end
	end
endmodule

/* File: core/eal_regs.vh */
// Constants of the EEPROM autoload and SMBus select block.
// Included by the core design files; holds definitions only.
// Functional notes
// RULE_01: Both straps low enable EEPROM master.
// RULE_02: Master drives SCL, data line both ways.
// RULE_03: Upper low, lower high selects SMBus slave.
// RULE_04: SMBus clock input, data open-drain only.
// RULE_05: Slave address 110 plus GPIO pins.
// RULE_06: Continue only on signature word 1516h.
// RULE_07: Byte 02h bits 4-1 choose stop.
// RULE_08: Byte 03h bit 0 locks ISA enable.
// RULE_09: Bytes 09h-0Bh load class code.
// RULE_10: Bytes 0Dh-0Eh load prefetch control.
// RULE_11: Byte 1Bh loads uncorrectable error mask.
// RULE_12: Bytes 22h-25h load clock control.
// RULE_13: Read ascending, store each byte first.
// RULE_14: Unloaded fields keep their reset defaults.
`ifndef EAL_REGS_VH
`define EAL_REGS_VH
`define EAL_CLK_NS 10
`define EAL_SCL_QTR_NS 2500
`define EAL_SCL_QTR_CYC ((`EAL_SCL_QTR_NS + `EAL_CLK_NS - 1) / `EAL_CLK_NS)
`define EAL_CMD_START 2'h0
`define EAL_CMD_STOP 2'h1
`define EAL_CMD_WRITE 2'h2
`define EAL_CMD_READ 2'h3
`define EAL_EE_DEV_WR 8'ha0
`define EAL_EE_DEV_RD 8'ha1
`define EAL_EE_FIRST 8'h00
`define EAL_SIG_WORD 16'h1516
`define EAL_EE_SIG_HI 8'h01
`define EAL_EE_REGION 8'h02
`define EAL_EE_MISC 8'h03
`define EAL_EE_CLASS0 8'h09
`define EAL_EE_CLASS1 8'h0a
`define EAL_EE_CLASS2 8'h0b
`define EAL_EE_PREF0 8'h0d
`define EAL_EE_PREF1 8'h0e
`define EAL_EE_ERRMASK 8'h1b
`define EAL_EE_CLK0 8'h22
`define EAL_EE_CLK1 8'h23
`define EAL_EE_CLK2 8'h24
`define EAL_EE_CLK3 8'h25
`define EAL_REGION_G1 4'h0
`define EAL_REGION_G2 4'h1
`define EAL_REGION_G3 4'h3
`define EAL_REGION_G4 4'h7
`define EAL_STOP_G1 8'h0b
`define EAL_STOP_G2 8'h67
`define EAL_STOP_G3 8'haf
`define EAL_STOP_G4 8'hd7
`define EAL_SMB_ADDR_HI 3'h6
`define EAL_RST_CLASS 24'h000000
`define EAL_RST_PREF 16'h0000
`define EAL_RST_ERRMASK 8'h00
`define EAL_RST_CLKCTL 32'h00000000
`define EAL_OFF_CTRL 8'h00
`define EAL_OFF_STATUS 8'h04
`define EAL_OFF_CLASS 8'h08
`define EAL_OFF_PREF 8'h0c
`define EAL_OFF_ERRMASK 8'h10
`define EAL_OFF_CLKCTL 8'h14
`define EAL_OFF_SMBADDR 8'h18
`define EAL_CTRL_START 0
`define EAL_ST_BUSY 0
`define EAL_ST_DONE 1
`define EAL_ST_SIGOK 2
`define EAL_ST_SIGFAIL 3
`define EAL_ST_NACK 4
`define EAL_ST_EEMODE 5
`define EAL_ST_SMBMODE 6
`define EAL_ST_ISARO 7
`endif

/* File: testbench/eal_autoload_asserts.sv */
// Concurrent checks on the pins of the autoload block.
// Assumes the straps change only while reset is held.
`timescale 1ns/1ns
module eal_autoload_asserts (
	input wire CORE_CLK,
	input wire RESET_N,
	input wire MODE_STRAP_HIGH,
	input wire MODE_STRAP_LOW,
	input wire TRANSPARENT_MODE,
	input wire MGMT_CLK_O,
	input wire MGMT_CLK_OE,
	input wire EEPROM_DATA_LINE_O,
	input wire EEPROM_DATA_LINE_OE,
	input wire [23:0] CFG_CLASS_CODE,
	input wire CFG_ISA_EN_RO,
	input wire LOAD_BUSY,
	input wire LOAD_DONE
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);
	sequence s_clk_high;
		MGMT_CLK_O [*8];
	endsequence
	sequence s_load_end;
		$rose(LOAD_DONE);
	endsequence
	property p_ee_mode;
		!MODE_STRAP_HIGH && !MODE_STRAP_LOW && $past(RESET_N) |=> MGMT_CLK_OE;
	endproperty
	property p_busy_ee;
		$rose(LOAD_BUSY) |-> MGMT_CLK_OE && !MODE_STRAP_LOW;
	endproperty
	property p_ee_only;
		MGMT_CLK_OE |-> !MODE_STRAP_HIGH && !MODE_STRAP_LOW;
	endproperty
	property p_smb_pins;
		MODE_STRAP_LOW && !MODE_STRAP_HIGH |->
			!MGMT_CLK_OE && !(EEPROM_DATA_LINE_OE && EEPROM_DATA_LINE_O);
	endproperty
	property p_clk_high;
		$rose(MGMT_CLK_O) |-> s_clk_high;
	endproperty
	property p_load_end;
		s_load_end |-> !LOAD_BUSY && MGMT_CLK_O;
	endproperty
	property p_isa;
		!TRANSPARENT_MODE |=> !CFG_ISA_EN_RO;
	endproperty
	property p_fields;
		!LOAD_BUSY && !$past(LOAD_BUSY) |-> $stable(CFG_CLASS_CODE);
	endproperty
	a_ee_mode: assert property (p_ee_mode)
		else $error("clock pin not driven in eeprom mode");
	a_busy_ee: assert property (p_busy_ee)
		else $error("load started outside eeprom mode");
	a_ee_only: assert property (p_ee_only)
		else $error("clock pin driven outside eeprom mode");
	a_smb_pins: assert property (p_smb_pins)
		else $error("pins driven in smbus mode");
	a_clk_high: assert property (p_clk_high)
		else $error("clock high phase too short");
	a_load_end: assert property (p_load_end)
		else $error("load ended with bus not idle");
	a_isa: assert property (p_isa)
		else $error("isa lock outside transparent mode");
	a_fields: assert property (p_fields)
		else $error("class code changed while idle");
endmodule
bind eal_autoload eal_autoload_asserts u_chk (.CORE_CLK, .RESET_N, .MODE_STRAP_HIGH,
	.MODE_STRAP_LOW, .TRANSPARENT_MODE, .MGMT_CLK_O, .MGMT_CLK_OE, .EEPROM_DATA_LINE_O,
	.EEPROM_DATA_LINE_OE, .CFG_CLASS_CODE, .CFG_ISA_EN_RO, .LOAD_BUSY, .LOAD_DONE);

/* File: testbench/eal_autoload_tb_top.sv */
// Top testbench of the autoload block with an EEPROM model on the shared pins.
// Register accesses wait on PREADY, so the port may add wait states.
`timescale 1ns/1ns
module eal_autoload_tb_top;
	logic core_clk, reset_n, s_hi, s_lo, transp, psel, penable, pwrite, err, smb_scl, smb_sda;
	logic [8:0] sb;
	logic [3:0] gpio;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd;
	wire clk_o, clk_oe, dat_o, dat_oe, pready, pslverr, busy, done, isa_ro, pull;
	wire [31:0] prdata, clk_ctrl;
	wire [23:0] class_code;
	wire [15:0] pref;
	wire [7:0] errmask;
	wire scl = clk_oe ? clk_o : smb_scl;
	// The memory sits on the pins only while the block is the bus master.
	wire sda = (dat_oe ? dat_o : 1'h1) & ~(pull & clk_oe) & smb_sda;
	int error_cnt, num_checks;
	eal_autoload #(.QTR_CYC(4)) dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .MODE_STRAP_HIGH(s_hi),
		.MODE_STRAP_LOW(s_lo), .GPIO(gpio), .TRANSPARENT_MODE(transp), .MGMT_CLK_I(scl),
		.MGMT_CLK_O(clk_o), .MGMT_CLK_OE(clk_oe), .EEPROM_DATA_LINE_I(sda),
		.EEPROM_DATA_LINE_O(dat_o), .EEPROM_DATA_LINE_OE(dat_oe), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CFG_CLASS_CODE(class_code),
		.CFG_PREFETCH_CTRL(pref), .CFG_UNCORR_ERR_MASK(errmask), .CFG_CLK_CTRL(clk_ctrl),
		.CFG_ISA_EN_RO(isa_ro), .LOAD_BUSY(busy), .LOAD_DONE(done));
	eal_ee_model ee (.scl(scl), .sda(sda), .pull(pull));
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic final_report;
		if (error_cnt == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic boot(input logic hi, input logic lo, input logic [3:0] g);
		reset_n <= 1'h0;
		s_hi <= hi;
		s_lo <= lo;
		gpio <= g;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'h1;
	endtask
	task automatic load;
		wait (busy === 1'h1);
		wait (busy === 1'h0);
	endtask
	// SMBus host: start (1) or stop (0) condition on the shared pins.
	task automatic smb_cond(input logic start);
		smb_sda <= start;
		repeat (4) @(posedge core_clk);
		smb_scl <= 1'h1;
		repeat (4) @(posedge core_clk);
		smb_sda <= ~start;
		repeat (4) @(posedge core_clk);
		if (start)
			smb_scl <= 1'h0;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic smb_bit(input logic b, output logic s);
		smb_sda <= b;
		repeat (4) @(posedge core_clk);
		smb_scl <= 1'h1;
		repeat (4) @(posedge core_clk);
		s = sda;
		smb_scl <= 1'h0;
		repeat (4) @(posedge core_clk);
	endtask
	// Eight bits MSB first, then a released ninth bit; got[0] is the ninth bit.
	task automatic smb_byte(input logic [7:0] b, output logic [8:0] got);
		for (int i = 8; i >= 0; i--)
			smb_bit((i > 0) ? b[i - 1] : 1'h1, got[i]);
	endtask
	initial begin
		#1_000_000;
		error_cnt++;
		final_report;
	end
	initial begin
		error_cnt = 0;
		num_checks = 0;
		reset_n = 1'h0;
		s_hi = 1'h0;
		s_lo = 1'h0;
		gpio = 4'h0;
		transp = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		smb_scl = 1'h1;
		smb_sda = 1'h1;
		for (int i = 0; i < 256; i++)
			ee.mem[i] = i[7:0] ^ 8'h5a;
		ee.mem[0] = 8'h16;
		ee.mem[1] = 8'h15;
		ee.mem[2] = 8'h00;
		ee.mem[3] = 8'h01;
		boot(1'h0, 1'h0, 4'h0);
		load;
		chk(clk_oe, 32'h1);
		chk(class_code, {ee.mem[11], ee.mem[10], ee.mem[9]});
		chk(pref, 32'h0);
		chk(errmask, 32'h0);
		chk(isa_ro, 32'h1);
		chk(done, 32'h1);
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, 32'ha6);
		ee.mem[2] = 8'h02;
		apb(1'h1, 8'h00, 32'h1);
		load;
		chk(pref, {ee.mem[14], ee.mem[13]});
		chk(errmask, ee.mem[27]);
		chk(clk_ctrl, {ee.mem[37], ee.mem[36], ee.mem[35], ee.mem[34]});
		ee.mem[1] = 8'h51;
		ee.mem[9] = 8'h77;
		apb(1'h1, 8'h00, 32'h1);
		load;
		chk(class_code, {ee.mem[11], ee.mem[10], 8'h53});
		apb(1'h0, 8'h04, 32'h0);
		chk(rd & 32'h0c, 32'h08);
		transp <= 1'h0;
		repeat (3) @(posedge core_clk);
		chk(isa_ro, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		boot(1'h0, 1'h1, 4'h9);
		repeat (2) @(posedge core_clk);
		apb(1'h1, 8'h00, 32'h1);
		repeat (4) @(posedge core_clk);
		chk({busy, clk_oe}, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		chk(rd, {24'h0, 3'h6, 4'h9, 1'h0});
		apb(1'h0, 8'h04, 32'h0);
		chk(rd & 32'h60, 32'h40);
		smb_cond(1'h1);
		smb_byte(8'hd4, sb);
		chk(sb[0], 32'h1);
		smb_cond(1'h1);
		smb_byte(8'hd2, sb);
		chk(sb[0], 32'h0);
		smb_byte(8'h5a, sb);
		chk(sb[0], 32'h0);
		smb_cond(1'h1);
		smb_byte(8'hd3, sb);
		chk(sb[0], 32'h0);
		smb_byte(8'hff, sb);
		chk(sb[8:1], 32'h40);
		smb_cond(1'h0);
		final_report;
	end
endmodule

/* File: testbench/eal_ee_model.sv */
// Behavioural serial EEPROM on the shared clock and data pins.
// Assumes an external pull-up on the data line; the memory only pulls it low.
`timescale 1ns/1ns
module eal_ee_model (
	input wire scl,
	input wire sda,
	output reg pull
);
	reg [7:0] mem [0:255];
	reg [7:0] sh;
	reg [7:0] ptr;
	reg [3:0] n;
	reg ph;
	reg rd;
	initial begin
		n = 4'h0;
		ph = 1'h0;
		rd = 1'h0;
		ptr = 8'h00;
		pull = 1'h0;
	end
	// A data edge while the clock is high is a start or stop.
	always @(sda) if (scl === 1'h1) begin
		n = 4'h0;
		ph = 1'h0;
		rd = 1'h0;
		pull = 1'h0;
	end
	always @(posedge scl) begin
		if (n < 4'h8)
			sh = {sh[6:0], sda};
		else if (rd && sda)
			rd = 1'h0;
		n = n + 4'h1;
	end
	// The line is only ever pulled low, never driven high.
	always @(negedge scl) begin
		if (n == 4'h8) begin
			if (rd) begin
				pull = 1'h0;
				ptr = ptr + 8'h01;
			end else if (!ph) begin
				pull = (sh[7:1] == 7'h50);
				rd = sh[0] & pull;
				ph = 1'h1;
			end else begin
				pull = 1'h1;
				ptr = sh;
			end
		end else if (n == 4'h9) begin
			n = 4'h0;
			pull = rd & ~mem[ptr][7];
		end else if (rd)
			pull = ~mem[ptr][3'h7 - n[2:0]];
	end
endmodule
